// >>> design/mps_pkg.sv
package mps_pkg;
  localparam int unsigned MPS_CLK_HZ = 125_000_000;
  // times in their own units, as specified
  localparam int unsigned MPS_ON_HOLD_S = 5;
  localparam int unsigned MPS_OFF_HOLD_S = 3;
  localparam int unsigned MPS_KILL_HOLD_MS = 200;
  localparam int unsigned MPS_QUIET_MS = 200;
  localparam int unsigned MPS_QUIET_USB_S = 10;
  localparam int unsigned MPS_DETACH_MS = 1000;
  localparam int unsigned MPS_FAST_MS = 300;
  localparam int unsigned MPS_POR_MS = 21;
  localparam int unsigned MPS_TIMEOUT_S = 20;
  // cycle counts, least times rounded up
  localparam longint MPS_ON_HOLD_CYC = longint'(MPS_ON_HOLD_S) * MPS_CLK_HZ;
  localparam longint MPS_OFF_HOLD_CYC = longint'(MPS_OFF_HOLD_S) * MPS_CLK_HZ;
  localparam longint MPS_KILL_HOLD_CYC = (longint'(MPS_KILL_HOLD_MS) * MPS_CLK_HZ + 999) / 1000;
  localparam longint MPS_QUIET_CYC = (longint'(MPS_QUIET_MS) * MPS_CLK_HZ + 999) / 1000;
  localparam longint MPS_QUIET_USB_CYC = longint'(MPS_QUIET_USB_S) * MPS_CLK_HZ;
  localparam longint MPS_DETACH_CYC = (longint'(MPS_DETACH_MS) * MPS_CLK_HZ + 999) / 1000;
  localparam longint MPS_FAST_CYC = (longint'(MPS_FAST_MS) * MPS_CLK_HZ + 999) / 1000;
  localparam longint MPS_POR_CYC = (longint'(MPS_POR_MS) * MPS_CLK_HZ + 999) / 1000;
  localparam longint MPS_TIMEOUT_CYC = longint'(MPS_TIMEOUT_S) * MPS_CLK_HZ;
  localparam int MPS_CW = 32;
  localparam logic [MPS_CW-1:0] MPS_CNT_ZERO = 32'h0000_0000;
  localparam logic [MPS_CW-1:0] MPS_CNT_ONE = 32'h0000_0001;
endpackage

// >>> design/mps_link_if.sv
`timescale 1ns/1ps
// open-drain lines with internal pull-up: low when any party drives
interface mps_link_if;
  logic pwr_toggle_oe;
  logic hard_kill_host_oe;
  logic hard_kill_dev_oe;
  logic power_good_indicator;
  logic fast_pd_gpio;
  logic pwr_toggle_n;
  logic hard_kill_n;
  assign pwr_toggle_n = ~pwr_toggle_oe;
  assign hard_kill_n = ~(hard_kill_host_oe | hard_kill_dev_oe);
  modport device (input pwr_toggle_n, input hard_kill_n, input fast_pd_gpio,
    output hard_kill_dev_oe, output power_good_indicator);
  modport host (input power_good_indicator, input hard_kill_n,
    output pwr_toggle_oe, output hard_kill_host_oe, output fast_pd_gpio);
endinterface

// >>> design/mps_timer.sv
`timescale 1ns/1ps
// down counter; done pulses one cycle when a loaded count expires
module mps_timer
  import mps_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic load,
  input wire logic [MPS_CW-1:0] count,
  output logic busy,
  output logic done
);
  logic [MPS_CW-1:0] remain;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      remain <= MPS_CNT_ZERO;
      done <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (load)
        remain <= count;
      else if (remain != MPS_CNT_ZERO)
      begin
        remain <= remain - MPS_CNT_ONE;
        if (remain == MPS_CNT_ONE)
          done <= 1'b1;
      end
    end
  end

  assign busy = (remain != MPS_CNT_ZERO);
endmodule

// >>> design/mps_host.sv
`timescale 1ns/1ps
// How it works
// - hold toggle low five seconds to start
// - toggle driven open-drain only, no pull-up
// - watch power-good to see start complete
// - no serial traffic first 200 ms
// - ten second wait with USB or update
// - start only above supply threshold, else kill
// - hold toggle low three seconds to stop
// - module detaches from network before off
// - power-good low confirms off state
// - kill low holds reset, stays off
// - hold kill low at least 200 ms
// - module drives kill during its start-up
// - kill driven open-collector only
// - kill reserved for emergency recovery
// - orderly power-off lasts over one second
// - falling fast-shutdown input starts fast off; the device acts on the fall only once fast_shutdown_command has armed it
// - fast shutdown lasts about 300 ms
// - keep lines low while module off
// - power-good stays high while powered on
module mps_host
  import mps_pkg::*;
#(
  parameter longint ON_HOLD = MPS_ON_HOLD_CYC,
  parameter longint OFF_HOLD = MPS_OFF_HOLD_CYC,
  parameter longint KILL_HOLD = MPS_KILL_HOLD_CYC,
  parameter longint QUIET = MPS_QUIET_CYC,
  parameter longint QUIET_USB = MPS_QUIET_USB_CYC,
  parameter longint TIMEOUT = MPS_TIMEOUT_CYC
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  mps_link_if.host link,
  input wire logic req_on,
  input wire logic req_off,
  input wire logic req_kill,
  input wire logic req_fast,
  input wire logic supply_ok,
  input wire logic usb_or_update,
  output logic serial_ready,
  output logic module_on,
  output logic fault,
  output logic busy
);
  typedef enum logic [6:0] {
    MPSH_OFF = 7'h01,
    MPSH_ON_PULSE = 7'h02,
    MPSH_WAIT_UP = 7'h04,
    MPSH_QUIET = 7'h08,
    MPSH_RUN = 7'h10,
    MPSH_OFF_PULSE = 7'h20,
    MPSH_WAIT_DOWN = 7'h40
  } mpsh_state_t;

  mpsh_state_t state;
  logic tm_load;
  logic [MPS_CW-1:0] tm_count;
  logic tm_done;
  logic kill_active;
  logic [MPS_CW-1:0] kill_cnt;
  logic pg;

  assign pg = link.power_good_indicator;

  // ============================================================
  // sequence timer
  mps_timer u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .load(tm_load),
    .count(tm_count),
    .busy(),
    .done(tm_done)
  );

  always_comb
  begin
    tm_load = 1'b0;
    tm_count = MPS_CNT_ZERO;
    case (state)
      MPSH_OFF:
        if (req_on && supply_ok && !kill_active)
        begin
          tm_load = 1'b1;
          tm_count = ON_HOLD[MPS_CW-1:0];
        end
      MPSH_ON_PULSE, MPSH_OFF_PULSE:
        if (tm_done)
        begin
          tm_load = 1'b1;
          tm_count = TIMEOUT[MPS_CW-1:0];
        end
      MPSH_WAIT_UP:
        if (pg)
        begin
          tm_load = 1'b1;
          tm_count = usb_or_update ? QUIET_USB[MPS_CW-1:0] : QUIET[MPS_CW-1:0];
        end
      MPSH_RUN:
        if (req_off)
        begin
          tm_load = 1'b1;
          tm_count = OFF_HOLD[MPS_CW-1:0];
        end
      default:
        tm_load = 1'b0;
    endcase
  end

  // ============================================================
  // sequencer
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      state <= MPSH_OFF;
    else if (ce)
    begin
      if (kill_active)
        state <= MPSH_OFF;
      else
        case (state)
          MPSH_OFF:
            if (req_on && supply_ok)
              state <= MPSH_ON_PULSE;
          MPSH_ON_PULSE:
            if (tm_done)
              state <= MPSH_WAIT_UP;
          MPSH_WAIT_UP:
            if (pg)
              state <= MPSH_QUIET;
            else if (tm_done)
              state <= MPSH_OFF;
          MPSH_QUIET:
            if (!pg)
              state <= MPSH_OFF;
            else if (tm_done)
              state <= MPSH_RUN;
          MPSH_RUN:
            if (!pg)
              state <= MPSH_OFF;
            else if (req_off)
              state <= MPSH_OFF_PULSE;
          MPSH_OFF_PULSE:
            if (tm_done)
              state <= MPSH_WAIT_DOWN;
          MPSH_WAIT_DOWN:
            if (!pg || tm_done)
              state <= MPSH_OFF;
          default:
            state <= MPSH_OFF;
        endcase
    end
  end

  // ============================================================
  // hard kill pulse, also the recovery when supply came up late
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      kill_active <= 1'b0;
      kill_cnt <= MPS_CNT_ZERO;
    end
    else if (ce)
    begin
      if (!kill_active && (req_kill || (state == MPSH_OFF && req_on && !supply_ok)))
      begin
        kill_active <= 1'b1;
        kill_cnt <= KILL_HOLD[MPS_CW-1:0];
      end
      else if (kill_active)
      begin
        if (kill_cnt == MPS_CNT_ONE)
          kill_active <= 1'b0;
        kill_cnt <= kill_cnt - MPS_CNT_ONE;
      end
    end
  end

  // ============================================================
  // line drivers and status, all registered
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      link.pwr_toggle_oe <= 1'b0;
      link.hard_kill_host_oe <= 1'b0;
      link.fast_pd_gpio <= 1'b0;
      serial_ready <= 1'b0;
      module_on <= 1'b0;
      fault <= 1'b0;
      busy <= 1'b0;
    end
    else if (ce)
    begin
      // pull low only, never drive high
      link.pwr_toggle_oe <= (state == MPSH_ON_PULSE || state == MPSH_OFF_PULSE)
        && !tm_done && !kill_active;
      link.hard_kill_host_oe <= kill_active;
      // raised once the module is up; a fall requests fast off and stays low
      // so the pin does not back-power the module while it shuts down
      link.fast_pd_gpio <= pg && !req_fast
        && (state == MPSH_QUIET || (state == MPSH_RUN && link.fast_pd_gpio));
      serial_ready <= (state == MPSH_RUN) && pg;
      module_on <= pg;
      busy <= (state != MPSH_OFF && state != MPSH_RUN) || kill_active;
      if (tm_done && (state == MPSH_WAIT_UP || state == MPSH_WAIT_DOWN))
        fault <= 1'b1;
      else if (req_on || req_off)
        fault <= 1'b0;
    end
  end
endmodule

// >>> design/mps_device.sv
`timescale 1ns/1ps
// module side of the power sequencing, one timer for the start-up reset, detach and fast off holds
module mps_device
  import mps_pkg::*;
#(
  parameter longint ON_HOLD = MPS_ON_HOLD_CYC,
  parameter longint OFF_HOLD = MPS_OFF_HOLD_CYC,
  parameter longint POR = MPS_POR_CYC,
  parameter longint DETACH = MPS_DETACH_CYC,
  parameter longint FAST = MPS_FAST_CYC
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  mps_link_if.device link,
  input wire logic shutdown_command,
  input wire logic fast_shutdown_command,
  output logic detach_req,
  output logic powered,
  output logic in_reset
);
  typedef enum logic [5:0] {
    MPSD_OFF = 6'h01,
    MPSD_POR = 6'h02,
    MPSD_ON = 6'h04,
    MPSD_DETACH = 6'h08,
    MPSD_FAST = 6'h10,
    MPSD_KILLED = 6'h20
  } mpsd_state_t;

  mpsd_state_t state;
  logic [MPS_CW-1:0] hold_cnt;
  logic fast_armed;
  logic gpio_q;
  logic tm_load;
  logic [MPS_CW-1:0] tm_count;
  logic tm_done;
  logic toggle_long;
  logic fast_fall;
  logic kill;

  assign kill = !link.hard_kill_n && !link.hard_kill_dev_oe;
  // taken on the last low cycle of the hold, so a pulse of exactly the hold counts
  assign toggle_long = !link.pwr_toggle_n && hold_cnt == ((state == MPSD_ON) ?
    OFF_HOLD[MPS_CW-1:0] - MPS_CNT_ONE : ON_HOLD[MPS_CW-1:0] - MPS_CNT_ONE);
  assign fast_fall = fast_armed && gpio_q && !link.fast_pd_gpio;

  mps_timer u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .load(tm_load),
    .count(tm_count),
    .busy(),
    .done(tm_done)
  );

  always_comb
  begin
    tm_load = 1'b0;
    tm_count = MPS_CNT_ZERO;
    if (state == MPSD_OFF && toggle_long)
    begin
      tm_load = 1'b1;
      tm_count = POR[MPS_CW-1:0];
    end
    else if (state == MPSD_ON && fast_fall)
    begin
      tm_load = 1'b1;
      tm_count = FAST[MPS_CW-1:0];
    end
    else if (state == MPSD_ON && (toggle_long || shutdown_command))
    begin
      tm_load = 1'b1;
      tm_count = DETACH[MPS_CW-1:0];
    end
  end

  // ============================================================
  // toggle low-time counter, cleared to zero when the needed hold is reached
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      hold_cnt <= MPS_CNT_ZERO;
    else if (ce)
    begin
      if (link.pwr_toggle_n || toggle_long || state == MPSD_DETACH)
        hold_cnt <= MPS_CNT_ZERO;
      else
        hold_cnt <= hold_cnt + MPS_CNT_ONE;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      gpio_q <= 1'b0;
      fast_armed <= 1'b0;
    end
    else if (ce)
    begin
      gpio_q <= link.fast_pd_gpio;
      if (state != MPSD_ON)
        fast_armed <= 1'b0;
      else if (fast_shutdown_command)
        fast_armed <= 1'b1;
    end
  end

  // ============================================================
  // power state machine
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      state <= MPSD_OFF;
    else if (ce)
    begin
      if (kill)
        state <= MPSD_KILLED;
      else
        case (state)
          MPSD_OFF:
            if (toggle_long)
              state <= MPSD_POR;
          MPSD_POR:
            if (tm_done)
              state <= MPSD_ON;
          MPSD_ON:
            if (fast_fall)
              state <= MPSD_FAST;
            else if (toggle_long || shutdown_command)
              state <= MPSD_DETACH;
          MPSD_DETACH, MPSD_FAST:
            if (tm_done)
              state <= MPSD_OFF;
          MPSD_KILLED:
            state <= MPSD_OFF;
          default:
            state <= MPSD_OFF;
        endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      link.hard_kill_dev_oe <= 1'b0;
      link.power_good_indicator <= 1'b0;
      detach_req <= 1'b0;
      powered <= 1'b0;
      in_reset <= 1'b0;
    end
    else if (ce)
    begin
      link.hard_kill_dev_oe <= (state == MPSD_POR) && !tm_done;
      // still powered while the fast shutdown runs; low once it is done, or at once on a hard kill
      link.power_good_indicator <= (state == MPSD_ON || state == MPSD_DETACH
        || state == MPSD_FAST) && !kill;
      detach_req <= (state == MPSD_ON) && !fast_fall && !kill
        && (toggle_long || shutdown_command);
      powered <= state != MPSD_OFF && state != MPSD_KILLED;
      in_reset <= kill;
    end
  end
endmodule

// >>> tb/mps_link_chk.sv
`timescale 1ns/1ps
// ==========================================
// link checker: sees only the drive enables and the power-good and fast gpio lines
module mps_link_chk #(
  parameter longint ON_HOLD = 50
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic pwr_toggle_oe,
  input wire logic hard_kill_host_oe,
  input wire logic hard_kill_dev_oe,
  input wire logic power_good_indicator,
  input wire logic fast_pd_gpio
);
  int unsigned hold_cnt;
  int unsigned last_hold;
  int unsigned quiet_cnt;
  logic gpio_q;

  // length of the last toggle pulse, latched when it ends
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      hold_cnt <= 0;
      last_hold <= 0;
    end
    else if (pwr_toggle_oe)
      hold_cnt <= hold_cnt + 1;
    else if (hold_cnt != 0)
    begin
      last_hold <= hold_cnt;
      hold_cnt <= 0;
    end

  // cycles without any host activity, saturating so it never wraps
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      quiet_cnt <= 0;
      gpio_q <= 1'h0;
    end
    else
    begin
      gpio_q <= fast_pd_gpio;
      if (pwr_toggle_oe || hard_kill_host_oe || gpio_q != fast_pd_gpio)
        quiet_cnt <= 0;
      else if (quiet_cnt != 63)
        quiet_cnt <= quiet_cnt + 1;
    end

  // ==========================================
  // properties
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  kill_drop_a: assert property (
    $rose(hard_kill_host_oe) |-> ##[1:4] !power_good_indicator)
    else $error("power good stayed high under hard kill");
  kill_hold_a: assert property (
    hard_kill_host_oe [*4] |-> !power_good_indicator)
    else $error("power good high while kill held");
  kill_off_a: assert property (
    $fell(hard_kill_host_oe) |-> !power_good_indicator [*8])
    else $error("module restarted after kill release");
  por_drive_a: assert property (
    $rose(hard_kill_dev_oe) |-> hard_kill_dev_oe [*4] ##[1:4] power_good_indicator)
    else $error("start-up reset drive too short or no power good");
  por_quiet_a: assert property (
    hard_kill_dev_oe |-> !power_good_indicator)
    else $error("power good high during start-up reset");
  on_hold_a: assert property (
    $rose(power_good_indicator) |-> last_hold >= ON_HOLD)
    else $error("module started after a short toggle pulse");
  idle_start_a: assert property (
    quiet_cnt == 63 |-> !$rose(power_good_indicator))
    else $error("module started with no toggle pulse");
  off_detach_a: assert property (
    $fell(pwr_toggle_oe) && power_good_indicator
      |-> power_good_indicator [*4] ##[1:24] !power_good_indicator)
    else $error("orderly off too quick or missing");
  fast_drop_a: assert property (
    $fell(fast_pd_gpio) && power_good_indicator |-> ##[1:60] !power_good_indicator)
    else $error("no power down after fast gpio fall");
endmodule

// >>> tb/test_modem_power_sequencing.sv
`timescale 1ns/1ps
// ==========================================
// both ends joined; short holds keep the run small
module test_modem_power_sequencing;
  localparam int ON_H = 50, OFF_H = 30, KILL_H = 10, QUIET = 8, QUIET_USB = 20;
  localparam int TMO = 400, POR = 5, DETACH = 12, FAST = 6;
  localparam int GPIO = 0, TOG = 1, KILL = 2, PG = 3, RDY = 4, ON = 5, FLT = 6, RST = 8, PWR = 9;
  logic mclk = 1'h0, rstn = 1'h0, dev_ce = 1'h1, supply_ok = 1'h1, usb_or_update = 1'h0;
  logic req_on = 1'h0, req_off = 1'h0, req_kill = 1'h0, req_fast = 1'h0, host_ce = 1'h1;
  logic shutdown_command = 1'h0, fast_shutdown_command = 1'h0;
  logic serial_ready, module_on, fault, busy, detach_req, powered, in_reset;
  logic [9:0] obs;
  int num_errors = 0, checks_done = 0, detach_cnt = 0, cyc = 0, detach_at = 0;

  mps_link_if link ();
  assign obs = {powered, in_reset, detach_req, fault, module_on, serial_ready,
    link.power_good_indicator, link.hard_kill_host_oe, link.pwr_toggle_oe, link.fast_pd_gpio};

  mps_host #(.ON_HOLD(ON_H), .OFF_HOLD(OFF_H), .KILL_HOLD(KILL_H), .QUIET(QUIET),
    .QUIET_USB(QUIET_USB), .TIMEOUT(TMO)) u_mps_host (.mclk(mclk), .rstn(rstn), .ce(host_ce),
    .link(link), .req_on(req_on), .req_off(req_off), .req_kill(req_kill), .req_fast(req_fast),
    .supply_ok(supply_ok), .usb_or_update(usb_or_update), .serial_ready(serial_ready),
    .module_on(module_on), .fault(fault), .busy(busy));
  mps_device #(.ON_HOLD(ON_H), .OFF_HOLD(OFF_H), .POR(POR), .DETACH(DETACH), .FAST(FAST))
    u_mps_device (.mclk(mclk), .rstn(rstn), .ce(dev_ce), .link(link),
    .shutdown_command(shutdown_command), .fast_shutdown_command(fast_shutdown_command),
    .detach_req(detach_req), .powered(powered), .in_reset(in_reset));
  mps_link_chk #(.ON_HOLD(ON_H)) u_mps_link_chk (.mclk(mclk), .rstn(rstn),
    .pwr_toggle_oe(link.pwr_toggle_oe), .hard_kill_host_oe(link.hard_kill_host_oe),
    .hard_kill_dev_oe(link.hard_kill_dev_oe), .fast_pd_gpio(link.fast_pd_gpio),
    .power_good_indicator(link.power_good_indicator));

  always #4 mclk = ~mclk;

  // detach is a one-cycle pulse, so count it at every edge
  always @(posedge mclk)
  begin
    cyc++;
    if (detach_req === 1'h1)
    begin
      detach_cnt++;
      detach_at = cyc;
    end
  end

  // ==========================================
  // helpers
  task automatic summarize;
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wait_for(input int sel, input logic val, input int lim, output int n);
    n = 0;
    while (obs[sel] !== val)
    begin
      @(negedge mclk);
      n++;
      if (n > lim)
      begin
        num_errors++;
        $display("MISMATCH wait on line %0d expected %0b", sel, val);
        summarize();
      end
    end
  endtask

  // ==========================================
  // scenarios
  task automatic power_on(input logic usb);
    int n;
    usb_or_update = usb;
    req_on = 1'h1;
    @(negedge mclk);
    req_on = 1'h0;
    wait_for(TOG, 1'h1, 4, n);
    check("fault cleared", obs[FLT], 1'h0);
    check("busy in pulse", busy, 1'h1);
    wait_for(TOG, 1'h0, ON_H + 2, n);
    check("on hold", n, ON_H);
    wait_for(PG, 1'h1, POR + 8, n);
    wait_for(RDY, 1'h1, QUIET_USB + 4, n);
    check("serial quiet", n >= (usb ? QUIET_USB : QUIET), 1'h1);
    check("module on", obs[ON], 1'h1);
    check("powered", obs[PWR], 1'h1);
    check("fast gpio up", obs[GPIO], 1'h1);
    check("idle when running", busy, 1'h0);
  endtask

  task automatic power_off;
    int n;
    int d;
    d = detach_cnt;
    req_off = 1'h1;
    @(negedge mclk);
    req_off = 1'h0;
    wait_for(TOG, 1'h1, 4, n);
    wait_for(TOG, 1'h0, OFF_H + 2, n);
    check("off hold", n, OFF_H);
    wait_for(PG, 1'h0, DETACH + OFF_H + 8, n);
    check("detach count", detach_cnt - d, 1);
    check("detach time", cyc - detach_at >= DETACH - 1, 1'h1);
    wait_for(ON, 1'h0, 4, n);
    check("lines low when off", obs[GPIO], 1'h0);
  endtask

  task automatic recover;
    int n;
    supply_ok = 1'h0;
    req_on = 1'h1;
    @(negedge mclk);
    req_on = 1'h0;
    wait_for(KILL, 1'h1, 4, n);
    check("toggle on low supply", obs[TOG], 1'h0);
    wait_for(KILL, 1'h0, KILL_H + 2, n);
    check("recovery kill hold", n, KILL_H);
    supply_ok = 1'h1;
    repeat (4) @(negedge mclk);
    power_on(1'h0);
  endtask

  task automatic shut_cmd;
    int n;
    int d;
    d = detach_cnt;
    shutdown_command = 1'h1;
    @(negedge mclk);
    shutdown_command = 1'h0;
    wait_for(PG, 1'h0, DETACH + 8, n);
    check("detach on command", detach_cnt - d, 1);
    wait_for(ON, 1'h0, 4, n);
  endtask

  task automatic kill;
    int n;
    int d;
    d = detach_cnt;
    req_kill = 1'h1;
    @(negedge mclk);
    req_kill = 1'h0;
    wait_for(KILL, 1'h1, 4, n);
    repeat (2) @(negedge mclk);
    check("held in reset", obs[RST], 1'h1);
    wait_for(KILL, 1'h0, KILL_H, n);
    check("kill hold", n, KILL_H - 2);
    repeat (2 * KILL_H) @(negedge mclk);
    check("off after kill", obs[PG], 1'h0);
    check("no detach on kill", detach_cnt - d, 0);
    check("host off after kill", obs[ON], 1'h0);
  endtask

  task automatic no_answer;
    int n;
    dev_ce = 1'h0;
    req_on = 1'h1;
    @(negedge mclk);
    req_on = 1'h0;
    wait_for(TOG, 1'h1, 4, n);
    // a frozen host must stretch the pulse by the frozen cycles
    host_ce = 1'h0;
    repeat (10) @(negedge mclk);
    host_ce = 1'h1;
    wait_for(TOG, 1'h0, ON_H + 2, n);
    check("frozen hold", n, ON_H);
    wait_for(FLT, 1'h1, ON_H + TMO + 8, n);
    check("timeout late enough", n >= TMO, 1'h1);
    check("not on", obs[ON], 1'h0);
    dev_ce = 1'h1;
  endtask

  task automatic fast_off;
    int n;
    fast_shutdown_command = 1'h1;
    @(negedge mclk);
    fast_shutdown_command = 1'h0;
    repeat (2) @(negedge mclk);
    req_fast = 1'h1;
    @(negedge mclk);
    req_fast = 1'h0;
    wait_for(GPIO, 1'h0, 4, n);
    wait_for(PG, 1'h0, FAST + 4, n);
    check("fast off time", n >= FAST - 1, 1'h1);
  endtask

  initial
  begin
    repeat (20) @(negedge mclk);
    rstn = 1'h1;
    @(negedge mclk);
    check("outputs after reset", obs, 10'h000);
    power_on(1'h0);
    power_off();
    recover();
    shut_cmd();
    power_on(1'h1);
    kill();
    no_answer();
    power_on(1'h0);
    fast_off();
    repeat (10) @(negedge mclk);
    summarize();
  end
endmodule
